// >>> include/pai_pkg.sv
// constants for the port A / port C pin integration block
// assumes an APB slave with 32-bit data and one register per aligned word
package pai_pkg;
  localparam int PA_W = 6;
  localparam int PC_W = 2;
  localparam int SPI_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PA_DATA = 6'h00;
  localparam logic [IDX_W-1:0] IDX_RSVD_A = 6'h01;
  localparam logic [IDX_W-1:0] IDX_PA_DIR = 6'h02;
  localparam logic [IDX_W-1:0] IDX_RSVD_B = 6'h03;
  localparam logic [IDX_W-1:0] IDX_PC_DATA = 6'h04;
  localparam logic [IDX_W-1:0] IDX_PC_DIR = 6'h06;
  localparam logic [1:0] ALIGN_OK = 2'h0;
  // reset values
  localparam logic [PA_W-1:0] PA_DATA_RST = 6'h00;
  localparam logic [PA_W-1:0] PA_DIR_RST = 6'h00;
  localparam logic [PC_W-1:0] PC_DATA_RST = 2'h0;
  localparam logic [PC_W-1:0] PC_DIR_RST = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
  // field positions
  localparam int PC_IRQ_BIT = 1;
  localparam int PC_CLK_BIT = 0;
  localparam int STRB_LANE0 = 0;
  localparam logic [PA_W-1:0] PA_ALL_OUT = 6'h3f;
  localparam logic [PC_W-1:0] PC_ALL_OUT = 2'h3;
endpackage

// >>> include/pai_pin_if.sv
// bundle between the register side and the per-pin output mux
// assumes all members are on the bus clock
`timescale 1ns/1ns
interface pai_pin_if #(parameter int W = 1);
  logic [W-1:0] gp_data;
  logic [W-1:0] gp_dir;
  logic [W-1:0] own;
  logic [W-1:0] alt_out;
  logic [W-1:0] alt_oe;
  logic [W-1:0] pin_out;
  logic [W-1:0] pin_oe;
  modport ctrl (output gp_data, output gp_dir, output own, output alt_out,
                output alt_oe, input pin_out, input pin_oe);
  modport mux (input gp_data, input gp_dir, input own, input alt_out,
               input alt_oe, output pin_out, output pin_oe);
endinterface

// >>> rtl/pai_sync.sv
// two-flop synchroniser for a vector of pin levels
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/1ns
module pai_sync #(parameter int W = 1) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // next values: first stage feeds only the second
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // register both stages
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule

// >>> rtl/pai_pin_mux.sv
// per-pin choice between GPIO and peripheral drive
// assumes own/alt signals come from logic on the same clock
`timescale 1ns/1ns
module pai_pin_mux #(parameter int W = 1) (
  pai_pin_if.mux p
);
  // one mux per pin
  for (genvar i = 0; i < W; i++) begin : g_pin
    always_comb begin
      if (p.own[i]) begin
        p.pin_out[i] = p.alt_out[i];
        p.pin_oe[i]  = p.alt_oe[i];
      end else begin
        p.pin_out[i] = p.gp_data[i];
        p.pin_oe[i]  = p.gp_dir[i];
      end
    end
  end
endmodule

// >>> rtl/pai_top.sv
// port A / port C pin integration with APB register access
// assumes APB master on clk_i, pins asynchronous, peripherals on clk_i
`timescale 1ns/1ns
module pai_top (
  input  wire logic                         clk_i,
  input  wire logic                         resetn_i,
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [pai_pkg::ADDR_W-1:0]   paddr_i,
  input  wire logic [pai_pkg::DATA_W-1:0]   pwdata_i,
  input  wire logic [3:0]                   pstrb_i,
  output logic      [pai_pkg::DATA_W-1:0]   prdata_o,
  output logic                              pready_o,
  output logic                              pslverr_o,
  input  wire logic [pai_pkg::PA_W-1:0]     pa_pin_i,
  output logic      [pai_pkg::PA_W-1:0]     pa_pin_o,
  output logic      [pai_pkg::PA_W-1:0]     pa_pin_oe_o,
  input  wire logic [pai_pkg::PC_W-1:0]     pc_pin_i,
  output logic      [pai_pkg::PC_W-1:0]     pc_pin_o,
  output logic      [pai_pkg::PC_W-1:0]     pc_pin_oe_o,
  output logic                              port_c_pin_one_pd_o,
  input  wire logic [pai_pkg::SPI_W-1:0]    spi_own_i,
  input  wire logic [pai_pkg::SPI_W-1:0]    spi_out_i,
  input  wire logic [pai_pkg::SPI_W-1:0]    spi_oe_i,
  output logic      [pai_pkg::SPI_W-1:0]    spi_in_o,
  input  wire logic                         die_link_en_i,
  input  wire logic                         die_link_clock_output_i,
  output logic                              die_link_irq_input_o
);
  logic [pai_pkg::PA_W-1:0]   pa_data_q;
  logic [pai_pkg::PA_W-1:0]   pa_data_d;
  logic [pai_pkg::PA_W-1:0]   pa_dir_q;
  logic [pai_pkg::PA_W-1:0]   pa_dir_d;
  logic [pai_pkg::PC_W-1:0]   pc_data_q;
  logic [pai_pkg::PC_W-1:0]   pc_data_d;
  logic [pai_pkg::PC_W-1:0]   pc_dir_q;
  logic [pai_pkg::PC_W-1:0]   pc_dir_d;
  logic [pai_pkg::DATA_W-1:0] prdata_q;
  logic [pai_pkg::DATA_W-1:0] prdata_d;
  logic [pai_pkg::PA_W-1:0]   pa_sync;
  logic [pai_pkg::PC_W-1:0]   pc_sync;
  logic [pai_pkg::PA_W-1:0]   pa_rd;
  logic [pai_pkg::PC_W-1:0]   pc_rd;
  logic [pai_pkg::IDX_W-1:0]  idx;
  logic                       aligned;
  logic                       hit;
  logic                       setup_rd;
  logic                       acc_wr;
  logic                       lane0;

  pai_pin_if #(.W(pai_pkg::PA_W)) pa_if ();
  pai_pin_if #(.W(pai_pkg::PC_W)) pc_if ();

  // input synchronisers for both ports
  pai_sync #(.W(pai_pkg::PA_W)) u_pa_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (pa_pin_i),
    .sync_o   (pa_sync)
  );

  pai_sync #(.W(pai_pkg::PC_W)) u_pc_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (pc_pin_i),
    .sync_o   (pc_sync)
  );

  // output muxes
  pai_pin_mux #(.W(pai_pkg::PA_W)) u_pa_mux (.p(pa_if.mux));
  pai_pin_mux #(.W(pai_pkg::PC_W)) u_pc_mux (.p(pc_if.mux));

  // address decode; byte address is four times the register index
  always_comb begin
    idx      = paddr_i[pai_pkg::ADDR_W-1:2];
    aligned  = (paddr_i[1:0] == pai_pkg::ALIGN_OK);
    hit      = aligned && ((idx == pai_pkg::IDX_PA_DATA) || (idx == pai_pkg::IDX_RSVD_A) ||
                           (idx == pai_pkg::IDX_PA_DIR)  || (idx == pai_pkg::IDX_RSVD_B) ||
                           (idx == pai_pkg::IDX_PC_DATA) || (idx == pai_pkg::IDX_PC_DIR));
    setup_rd = psel_i && !penable_i && !pwrite_i;
    acc_wr   = psel_i && penable_i && pwrite_i && aligned;
    lane0    = pstrb_i[pai_pkg::STRB_LANE0];
  end

  // zero wait states; unmapped or misaligned access answers with an error
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;

  // read value per pin: register when output, synced pin when input
  for (genvar i = 0; i < pai_pkg::PA_W; i++) begin : g_pa_rd
    assign pa_rd[i] = pa_dir_q[i] ? pa_data_q[i] : pa_sync[i];
  end
  for (genvar i = 0; i < pai_pkg::PC_W; i++) begin : g_pc_rd
    assign pc_rd[i] = pc_dir_q[i] ? pc_data_q[i] : pc_sync[i];
  end

  // next register values: writes land at the access edge only
  always_comb begin
    pa_data_d = pa_data_q;
    pa_dir_d  = pa_dir_q;
    pc_data_d = pc_data_q;
    pc_dir_d  = pc_dir_q;
    if (acc_wr && lane0) begin
      case (idx)
        pai_pkg::IDX_PA_DATA: pa_data_d = pwdata_i[pai_pkg::PA_W-1:0];
        pai_pkg::IDX_PA_DIR:  pa_dir_d  = pwdata_i[pai_pkg::PA_W-1:0];
        pai_pkg::IDX_PC_DATA: pc_data_d = pwdata_i[pai_pkg::PC_W-1:0];
        pai_pkg::IDX_PC_DIR:  pc_dir_d  = pwdata_i[pai_pkg::PC_W-1:0];
        default: begin
          pa_data_d = pa_data_q;
        end
      endcase
    end
  end

  // next read data, captured in the setup cycle; upper bits stay zero
  always_comb begin
    prdata_d = prdata_q;
    if (setup_rd) begin
      prdata_d = pai_pkg::RDATA_RST;
      if (aligned) begin
        case (idx)
          pai_pkg::IDX_PA_DATA: prdata_d[pai_pkg::PA_W-1:0] = pa_rd;
          pai_pkg::IDX_PA_DIR:  prdata_d[pai_pkg::PA_W-1:0] = pa_dir_q;
          pai_pkg::IDX_PC_DATA: prdata_d[pai_pkg::PC_W-1:0] = pc_rd;
          pai_pkg::IDX_PC_DIR:  prdata_d[pai_pkg::PC_W-1:0] = pc_dir_q;
          default: begin
            prdata_d = pai_pkg::RDATA_RST;
          end
        endcase
      end
    end
  end

  // register the state; peripherals never touch the direction bits
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pa_data_q <= pai_pkg::PA_DATA_RST;
      pa_dir_q  <= pai_pkg::PA_DIR_RST;
      pc_data_q <= pai_pkg::PC_DATA_RST;
      pc_dir_q  <= pai_pkg::PC_DIR_RST;
      prdata_q  <= pai_pkg::RDATA_RST;
    end else begin
      pa_data_q <= pa_data_d;
      pa_dir_q  <= pa_dir_d;
      pc_data_q <= pc_data_d;
      pc_dir_q  <= pc_dir_d;
      prdata_q  <= prdata_d;
    end
  end

  assign prdata_o = prdata_q;

  // port A: SPI owns pins 3..0 when it says so, pins 5..4 are plain GPIO
  always_comb begin
    pa_if.gp_data = pa_data_q;
    pa_if.gp_dir  = pa_dir_q;
    pa_if.own     = '0;
    pa_if.alt_out = '0;
    pa_if.alt_oe  = '0;
    pa_if.own[pai_pkg::SPI_W-1:0]     = spi_own_i;
    pa_if.alt_out[pai_pkg::SPI_W-1:0] = spi_out_i;
    pa_if.alt_oe[pai_pkg::SPI_W-1:0]  = spi_oe_i;
  end

  // port C: link drives the clock on pin 0 and listens on pin 1
  always_comb begin
    pc_if.gp_data = pc_data_q;
    pc_if.gp_dir  = pc_dir_q;
    pc_if.own     = {pai_pkg::PC_W{die_link_en_i}};
    pc_if.alt_out = '0;
    pc_if.alt_oe  = '0;
    pc_if.alt_out[pai_pkg::PC_CLK_BIT] = die_link_clock_output_i;
    pc_if.alt_oe[pai_pkg::PC_CLK_BIT]  = 1'b1;
    pc_if.alt_oe[pai_pkg::PC_IRQ_BIT]  = 1'b0;
  end

  // pin drive and peripheral inputs
  assign pa_pin_o             = pa_if.pin_out;
  assign pa_pin_oe_o          = pa_if.pin_oe;
  assign pc_pin_o             = pc_if.pin_out;
  assign pc_pin_oe_o          = pc_if.pin_oe;
  assign spi_in_o             = pa_sync[pai_pkg::SPI_W-1:0];
  assign die_link_irq_input_o = die_link_en_i & pc_sync[pai_pkg::PC_IRQ_BIT];
  assign port_c_pin_one_pd_o  = die_link_en_i;

  // checks on the block's outputs and internal registers
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  logic rd_pa_setup;
  logic rd_pc_setup;
  logic rd_rsvd_setup;
  logic wr_rsvd;
  logic wr_pa_dir;
  logic wr_pc_dir;

  // helper decode for the checks
  always_comb begin
    rd_pa_setup   = setup_rd && aligned && (idx == pai_pkg::IDX_PA_DATA);
    rd_pc_setup   = setup_rd && aligned && (idx == pai_pkg::IDX_PC_DATA);
    rd_rsvd_setup = setup_rd && aligned && (idx == pai_pkg::IDX_RSVD_A);
    wr_rsvd       = acc_wr && (idx == pai_pkg::IDX_RSVD_A);
    wr_pa_dir     = acc_wr && lane0 && (idx == pai_pkg::IDX_PA_DIR);
    wr_pc_dir     = acc_wr && lane0 && (idx == pai_pkg::IDX_PC_DIR);
  end

  a_pa_out_read: assert property (
    rd_pa_setup && (pa_dir_q == pai_pkg::PA_ALL_OUT) |=>
      prdata_o == {26'h0, $past(pa_data_q)})
    else $error("port A output read not register value");

  a_pa_in_read: assert property (
    rd_pa_setup && (pa_dir_q == pai_pkg::PA_DIR_RST) |=>
      prdata_o[pai_pkg::PA_W-1:0] == $past(pa_sync))
    else $error("port A input read not synced pin");

  // only edges that ran out of reset count, else the flops still hold their reset value
  a_sync_two_flop: assert property (
    $past(resetn_i) && $past(resetn_i, 2) |-> pa_sync == $past(pa_pin_i, 2))
    else $error("pin sync latency not two cycles");

  a_pa_write_data: assert property (
    acc_wr && lane0 && (idx == pai_pkg::IDX_PA_DATA) |=>
      pa_data_q == $past(pwdata_i[pai_pkg::PA_W-1:0]))
    else $error("port A data write lost");

  a_pc_out_read: assert property (
    rd_pc_setup && (pc_dir_q == pai_pkg::PC_ALL_OUT) |=>
      prdata_o == {30'h0, $past(pc_data_q)})
    else $error("port C output read wrong");

  a_rsvd_read_zero: assert property (
    rd_rsvd_setup |=> prdata_o == pai_pkg::RDATA_RST)
    else $error("reserved location not zero");

  a_rsvd_write_none: assert property (
    wr_rsvd |=> $stable(pa_data_q) && $stable(pa_dir_q) && $stable(pc_data_q))
    else $error("reserved write changed state");

  a_pa_dir_kept: assert property (
    !wr_pa_dir |=> $stable(pa_dir_q))
    else $error("port A direction changed without write");

  a_pc_dir_kept: assert property (
    !wr_pc_dir |=> $stable(pc_dir_q))
    else $error("port C direction changed without write");

  a_spi_drive: assert property (
    spi_own_i[2] |-> (pa_pin_o[2] == spi_out_i[2]) && (pa_pin_oe_o[2] == spi_oe_i[2]))
    else $error("SPI owned pin not driven by SPI");

  a_gpio_pin_five: assert property (
    (pa_pin_oe_o[5] == pa_dir_q[5]) && (pa_dir_q[5] -> pa_pin_o[5] == pa_data_q[5]))
    else $error("GPIO pin not following data and direction");

  a_gpio_unowned: assert property (
    !spi_own_i[0] |-> (pa_pin_oe_o[0] == pa_dir_q[0]))
    else $error("free SPI pin not plain GPIO");

  a_link_clock: assert property (
    die_link_en_i |-> pc_pin_oe_o[0] && (pc_pin_o[0] == die_link_clock_output_i))
    else $error("link clock not on port C pin 0");

  a_link_irq_in: assert property (
    die_link_en_i |-> !pc_pin_oe_o[1] && port_c_pin_one_pd_o)
    else $error("port C pin 1 not input with pull-down");

  a_link_irq_path: assert property (
    die_link_en_i && $stable(pc_pin_i) [*3] ##0 ($past(resetn_i) && $past(resetn_i, 2))
      |-> die_link_irq_input_o == pc_pin_i[1])
    else $error("link irq input not following pin");

  a_bad_addr_err: assert property (
    psel_i && penable_i && !aligned |-> pslverr_o)
    else $error("misaligned access not refused");

  // read data and write paths not covered above
  a_upper_read_zero: assert property (
    prdata_o[pai_pkg::DATA_W-1:pai_pkg::PA_W] == '0)
    else $error("read data upper bits not zero");

  a_pc_upper_zero: assert property (
    rd_pc_setup |=> prdata_o[pai_pkg::DATA_W-1:pai_pkg::PC_W] == '0)
    else $error("port C read upper bits not zero");

  a_pc_in_read: assert property (
    rd_pc_setup && (pc_dir_q == pai_pkg::PC_DIR_RST) |=>
      prdata_o[pai_pkg::PC_W-1:0] == $past(pc_sync))
    else $error("port C input read not synced pin");

  a_pa_dir_write: assert property (
    wr_pa_dir |=> pa_dir_q == $past(pwdata_i[pai_pkg::PA_W-1:0]))
    else $error("port A direction write lost");

  a_pc_data_write: assert property (
    acc_wr && lane0 && (idx == pai_pkg::IDX_PC_DATA) |=>
      pc_data_q == $past(pwdata_i[pai_pkg::PC_W-1:0]))
    else $error("port C data write lost");

  a_rsvd_b_zero: assert property (
    setup_rd && aligned && (idx == pai_pkg::IDX_RSVD_B) |=>
      prdata_o == pai_pkg::RDATA_RST)
    else $error("second reserved location not zero");

  // pin ownership checks
  a_spi_all_pins: assert property (
    (&spi_own_i) |-> (pa_pin_o[pai_pkg::SPI_W-1:0] == spi_out_i) &&
      (pa_pin_oe_o[pai_pkg::SPI_W-1:0] == spi_oe_i))
    else $error("SPI owned pins not driven by SPI");

  a_pa_top_gpio: assert property (
    pa_pin_oe_o[pai_pkg::PA_W-1:pai_pkg::SPI_W] ==
      pa_dir_q[pai_pkg::PA_W-1:pai_pkg::SPI_W])
    else $error("port A upper pins not plain GPIO");

  a_pc_gpio_free: assert property (
    !die_link_en_i |-> (pc_pin_oe_o == pc_dir_q) && (pc_pin_o == pc_data_q))
    else $error("free port C pins not plain GPIO");

  c_pa_write_read: cover property (
    acc_wr && (idx == pai_pkg::IDX_PA_DATA) ##1 rd_pa_setup);
  c_spi_owns: cover property (spi_own_i == 4'hf && pa_dir_q != pai_pkg::PA_DIR_RST);
  c_link_on: cover property (die_link_en_i && rd_pc_setup);
  c_pa_input_read: cover property (
    rd_pa_setup && (pa_dir_q == pai_pkg::PA_DIR_RST));
  c_rsvd_write: cover property (
    wr_rsvd ##1 rd_rsvd_setup);
endmodule

// >>> dv/pai_periph_model.sv
// behavioural SPI master and die link on the peripheral side of pai_top
// assumes the bench selects modes; everything runs on clk_i
`timescale 1ns/1ns
module pai_periph_model (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       spi_on_i,
  input  wire logic       link_on_i,
  output logic      [3:0] spi_own_o,
  output logic      [3:0] spi_out_o,
  output logic      [3:0] spi_oe_o,
  output logic            link_en_o,
  output logic            link_clk_o
);
  logic [3:0] junk_q;
  // released lines show a changing pattern; link clock stands still when off
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      junk_q <= 4'h0;
      link_clk_o <= 1'b0;
    end else begin
      junk_q <= junk_q + 4'h3;
      link_clk_o <= link_on_i ? ~link_clk_o : 1'b0;
    end
  end
  // master drives select, clock and mosi, takes miso in
  assign spi_own_o = spi_on_i ? 4'hf : 4'h0;
  assign spi_out_o = spi_on_i ? 4'ha : junk_q;
  assign spi_oe_o  = spi_on_i ? 4'he : ~junk_q;
  assign link_en_o = link_on_i;
endmodule

// >>> dv/test_port_a_c_pin_integration.sv
// self-checking bench for pai_top: APB register access, pins, peripherals
// assumes pads resolve from the enables; external levels set by the bench
`timescale 1ns/1ns
module test_port_a_c_pin_integration;
  typedef struct {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] ex;
  } pai_row_t;
  logic        clk_i    = 1'b0;
  logic        resetn_i = 1'b0;
  logic        psel     = 1'b0;
  logic        pen      = 1'b0;
  logic        pwr      = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  pa_in;
  logic [5:0]  pa_out;
  logic [5:0]  pa_oe;
  logic [5:0]  ext_a    = 6'h15;
  logic [1:0]  pc_in;
  logic [1:0]  pc_out;
  logic [1:0]  pc_oe;
  logic [1:0]  ext_c    = 2'h2;
  logic        pd;
  logic        irq;
  logic        spi_on   = 1'b0;
  logic        link_on  = 1'b0;
  logic [3:0]  s_own;
  logic [3:0]  s_out;
  logic [3:0]  s_oe;
  logic [3:0]  s_in;
  logic        l_en;
  logic        l_clk;
  logic [31:0] r;
  logic        e;
  int          err_count = 0;
  int          cmp_count = 0;
  pai_row_t    rows[9] = '{
    '{8'h08, 32'h3f, 8'h08, 32'h3f}, '{8'h00, 32'h2a, 8'h00, 32'h2a},
    '{8'h00, 32'hff, 8'h00, 32'h3f}, '{8'h08, 32'h30, 8'h00, 32'h35},
    '{8'h04, 32'hff, 8'h04, 32'h00}, '{8'h0c, 32'hff, 8'h0c, 32'h00},
    '{8'h18, 32'h03, 8'h18, 32'h03}, '{8'h10, 32'hff, 8'h10, 32'h03},
    '{8'h18, 32'h00, 8'h10, 32'h02}};
  // pads: a driven pin shows its drive, otherwise the external level
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);
  // clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  pai_periph_model peer (.clk_i(clk_i), .resetn_i(resetn_i), .spi_on_i(spi_on),
    .link_on_i(link_on), .spi_own_o(s_own), .spi_out_o(s_out), .spi_oe_o(s_oe),
    .link_en_o(l_en), .link_clk_o(l_clk));
  pai_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pa_pin_i(pa_in),
    .pa_pin_o(pa_out), .pa_pin_oe_o(pa_oe), .pc_pin_i(pc_in), .pc_pin_o(pc_out),
    .pc_pin_oe_o(pc_oe), .port_c_pin_one_pd_o(pd), .spi_own_i(s_own),
    .spi_out_i(s_out), .spi_oe_i(s_oe), .spi_in_o(s_in), .die_link_en_i(l_en),
    .die_link_clock_output_i(l_clk), .die_link_irq_input_o(irq));
  // value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one APB transfer, then idle cycles so synchronisers settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    chk(pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic final_report();
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(50 * 4000);
    err_count++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    chk(pa_oe, 6'h00);
    rd(8'h08, 32'h00);
    rd(8'h00, 32'h15);
    rd(8'h10, 32'h02);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].wa, rows[i].wd);
      rd(rows[i].ra, rows[i].ex);
    end
    chk(pa_oe, 6'h30);
    chk(pa_out[5:4], 2'h3);
    chk(pc_oe, 2'h0);
    chk(pc_out, 2'h3);
    // SPI takes pins 3..0
    spi_on <= 1'b1;
    rd(8'h08, 32'h30);
    chk(pa_out[3:0], 4'ha);
    chk(pa_oe, 6'h3e);
    chk(s_in, 4'hb);
    spi_on <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(s_in, 4'h5);
    ext_a <= 6'h14;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(s_in, 4'h5);
    @(negedge clk_i);
    chk(s_in, 4'h4);
    // die link takes both port C pins
    @(posedge clk_i);
    link_on <= 1'b1;
    rd(8'h18, 32'h00);
    chk(pc_oe, 2'h1);
    chk(pd, 1'b1);
    chk(irq, 1'b1);
    @(negedge clk_i);
    chk(pc_out[0], l_clk);
    @(posedge clk_i);
    link_on <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(pd, 1'b0);
    chk(irq, 1'b0);
    // unmapped address is refused
    apb(1'b0, 8'h40, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    // second reset in mid-run
    resetn_i <= 1'b0;
    @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(8'h08, 32'h00);
    rd(8'h00, 32'h14);
    final_report();
  end
endmodule
